// *** mol_overload_limiter.sv ***
// Motor overload current limiter with AHB-Lite register slave.
// Assumes motor current samples synchronous to hclk, one bus master.
`timescale 1ns/100ps
module mol_overload_limiter
    import mol_pkg::*;
#(
    parameter int CTRL_PERIOD_CYCLES = MOL_PERIOD_CYCLES
)
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Current path
    input  wire logic [15:0] motor_current_ma,
    input  wire logic [15:0] current_cmd_ma,
    output logic      [15:0] current_cmd_limited_ma,
    output logic      [15:0] applied_current_limit,
    output logic             protection_active
);

    typedef struct packed {
        logic [31:0] rdata;
        logic        wr_pend;
        logic [7:0]  wr_ofs;
        logic        closed_loop;
        logic [15:0] max_motor_ma;
        logic [15:0] rated_ma;
        logic [15:0] peak_permille;
        logic [15:0] peak_dur_ms;
        logic [31:0] tick_cnt;
        logic [47:0] acc;
        logic [47:0] thr_sq;
        logic [31:0] thr_mas;
        mol_lim_e    lim;
        logic [15:0] applied_ma;
        logic [15:0] cmd_lim_ma;
        logic        active;
    } mol_state_s;

    localparam logic [31:0] PERIOD_LAST = 32'(CTRL_PERIOD_CYCLES - 1);

    mol_state_s  st_q;
    mol_state_s  st_d;
    logic        addr_ok;
    logic        tick;
    logic        over;
    logic [15:0] diff;
    logic [31:0] sq;
    logic [48:0] sum;
    logic        calc_active;
    logic [15:0] peak_c;
    logic [47:0] thr_sq_c;
    logic [31:0] thr_mas_c;

    // Settings to peak, activation and threshold
    mol_limit_calc i_mol_limit_calc (
        .closed_loop   (st_q.closed_loop),
        .max_motor_ma  (st_q.max_motor_ma),
        .rated_ma      (st_q.rated_ma),
        .peak_permille (st_q.peak_permille),
        .peak_dur_ms   (st_q.peak_dur_ms),
        .active        (calc_active),
        .peak_ma       (peak_c),
        .thr_sq        (thr_sq_c),
        .thr_mas       (thr_mas_c)
    );

    always_comb
    begin
        st_d = st_q;
        addr_ok = hsel && hready && htrans[1];
        tick = (st_q.tick_cnt == PERIOD_LAST);
        over = motor_current_ma > st_q.rated_ma;
        diff = over ? (motor_current_ma - st_q.rated_ma)
                    : (st_q.rated_ma - motor_current_ma);
        sq = diff * diff;
        sum = {1'b0, st_q.acc} + {17'h00000, sq};

        // Data phase of a write
        if (st_q.wr_pend)
        begin
            case (st_q.wr_ofs)
                MOL_OFS_CTRL:     st_d.closed_loop = hwdata[MOL_CTRL_CLOSED_BIT];
                MOL_OFS_MAX_MOT:  st_d.max_motor_ma = hwdata[15:0];
                MOL_OFS_RATED:    st_d.rated_ma = hwdata[15:0];
                MOL_OFS_PEAK_PM:  st_d.peak_permille = hwdata[15:0];
                MOL_OFS_PEAK_DUR: st_d.peak_dur_ms = hwdata[15:0];
                default:          st_d.wr_ofs = st_q.wr_ofs;
            endcase
        end
        st_d.wr_pend = addr_ok && hwrite && (hsize == MOL_HSIZE_WORD);
        st_d.wr_ofs = haddr[7:0];

        // Address phase of a read
        if (addr_ok && !hwrite)
        begin
            case (haddr[7:0])
                MOL_OFS_CTRL:     st_d.rdata = {31'h0, st_q.closed_loop};
                MOL_OFS_MAX_MOT:  st_d.rdata = {16'h0000, st_q.max_motor_ma};
                MOL_OFS_RATED:    st_d.rdata = {16'h0000, st_q.rated_ma};
                MOL_OFS_PEAK_PM:  st_d.rdata = {16'h0000, st_q.peak_permille};
                MOL_OFS_PEAK_DUR: st_d.rdata = {16'h0000, st_q.peak_dur_ms};
                MOL_OFS_THRESH:   st_d.rdata = st_q.thr_mas;
                MOL_OFS_ACC_LO:   st_d.rdata = st_q.acc[31:0];
                MOL_OFS_ACC_HI:   st_d.rdata = {16'h0000, st_q.acc[47:32]};
                MOL_OFS_LIMIT:    st_d.rdata = {16'h0000, st_q.applied_ma};
                MOL_OFS_STATUS:   st_d.rdata = {31'h0, st_q.active};
                default:          st_d.rdata = 32'h0000_0000;
            endcase
        end

        // Control period counter
        st_d.tick_cnt = tick ? 32'h0000_0000 : (st_q.tick_cnt + 32'h0000_0001);

        if (!calc_active)
            st_d.acc = 48'h0000_0000_0000;
        else if (tick)
        begin
            if (over)
                st_d.acc = sum[48] ? {48{1'b1}} : sum[47:0];
            else if (st_q.acc > {16'h0000, sq})
                st_d.acc = st_q.acc - {16'h0000, sq};
            else
                st_d.acc = 48'h0000_0000_0000;
        end

        st_d.thr_sq = thr_sq_c;
        st_d.thr_mas = thr_mas_c;
        st_d.active = calc_active;

        if (calc_active && (st_d.acc >= thr_sq_c))
            st_d.lim = MOL_LIM_RATED;
        else
            st_d.lim = MOL_LIM_PEAK;
        st_d.applied_ma = (st_d.lim == MOL_LIM_RATED) ? st_q.rated_ma : peak_c;
        if (current_cmd_ma > st_d.applied_ma)
            st_d.cmd_lim_ma = st_d.applied_ma;
        else
            st_d.cmd_lim_ma = current_cmd_ma;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q <= '{
                rdata:         32'h0000_0000,
                wr_pend:       1'b0,
                wr_ofs:        8'h00,
                closed_loop:   MOL_RST_CLOSED,
                max_motor_ma:  MOL_RST_MAX_MOT,
                rated_ma:      MOL_RST_RATED,
                peak_permille: MOL_RST_PEAK_PM,
                peak_dur_ms:   MOL_RST_PEAK_DUR,
                tick_cnt:      32'h0000_0000,
                acc:           48'h0000_0000_0000,
                thr_sq:        48'h0000_0000_0000,
                thr_mas:       32'h0000_0000,
                lim:           MOL_LIM_PEAK,
                applied_ma:    16'h0000,
                cmd_lim_ma:    16'h0000,
                active:        1'b0
            };
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign hreadyout              = 1'b1;
    assign hresp                  = 1'b0;
    assign hrdata                 = st_q.rdata;
    assign applied_current_limit  = st_q.applied_ma;
    assign current_cmd_limited_ma = st_q.cmd_lim_ma;
    assign protection_active      = st_q.active;

    open_loop_off_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!st_q.closed_loop) |=> (!protection_active && st_q.acc == 48'h0))
        else $error("protection active without closed loop");

    zero_dur_off_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        protection_active |-> ($past(st_q.peak_dur_ms) != 16'h0000
                               && applied_current_limit >= $past(st_q.rated_ma)))
        else $error("active with zero duration or low limit");

    cut_to_rated_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (protection_active && st_q.acc >= st_q.thr_sq)
        |-> (st_q.lim == MOL_LIM_RATED
             && applied_current_limit == $past(st_q.rated_ma)))
        else $error("limit reached but current not cut to rated");

    ceiling_clamp_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        protection_active |-> applied_current_limit <= $past(st_q.max_motor_ma))
        else $error("applied limit above motor ceiling");

    peak_scale_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (protection_active && st_q.lim == MOL_LIM_PEAK)
        |-> (32'(applied_current_limit) * 32'd1000
             <= $past(st_q.rated_ma) * $past(st_q.peak_permille)))
        else $error("peak limit exceeds permille of rated");

    load_grows_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (tick && calc_active && over && st_q.acc != {48{1'b1}})
        |=> (st_q.acc > $past(st_q.acc)))
        else $error("load did not grow under overcurrent");

    load_decays_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (tick && calc_active && !over && diff != 16'h0 && st_q.acc != 48'h0)
        |=> (st_q.acc < $past(st_q.acc)))
        else $error("load did not decay below rated");

    // while active, load only moves on a tick
    load_hold_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!tick && calc_active) |=> (st_q.acc == $past(st_q.acc)))
        else $error("load changed outside control period");

    limit_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite && haddr[7:0] == MOL_OFS_LIMIT)
        |=> (hrdata == {16'h0000, $past(applied_current_limit)}))
        else $error("limit readback mismatch");

    status_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite && haddr[7:0] == MOL_OFS_STATUS)
        |=> (hrdata == {31'h0, $past(protection_active)}))
        else $error("status readback mismatch");

    thresh_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite && haddr[7:0] == MOL_OFS_THRESH)
        |=> (hrdata == $past(st_q.thr_mas)))
        else $error("threshold readback mismatch");

    dur_zero_off_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (st_q.peak_dur_ms == 16'h0000) |=> !protection_active)
        else $error("active although duration is zero");

    peak_low_off_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (peak_c <= st_q.rated_ma) |=> !protection_active)
        else $error("active although peak not above rated");

    active_on_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (st_q.closed_loop && peak_c > st_q.rated_ma && st_q.peak_dur_ms != 16'h0000)
        |=> protection_active)
        else $error("conditions met but status not active");

    thr_idle_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !calc_active |=> (st_q.thr_sq == 48'h0 && st_q.thr_mas == 32'h0))
        else $error("threshold nonzero while inactive");

    acc_lo_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite && haddr[7:0] == MOL_OFS_ACC_LO)
        |=> (hrdata == $past(st_q.acc[31:0])))
        else $error("load low word readback mismatch");

    acc_hi_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite && haddr[7:0] == MOL_OFS_ACC_HI)
        |=> (hrdata == {16'h0000, $past(st_q.acc[47:32])}))
        else $error("load high word readback mismatch");

    cmd_clamp_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> (current_cmd_limited_ma <= applied_current_limit
                  && current_cmd_limited_ma <= $past(current_cmd_ma)
                  && (current_cmd_limited_ma == applied_current_limit
                      || current_cmd_limited_ma == $past(current_cmd_ma))))
        else $error("limited command out of range");

    tick_range_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        st_q.tick_cnt <= PERIOD_LAST)
        else $error("period counter out of range");

endmodule

// *** mol_pkg.sv ***
// Constants and types for the motor overload current limiter.
// Assumes a 40 MHz control clock and an AHB-Lite register port.
package mol_pkg;

    // Register byte offsets
    localparam logic [7:0] MOL_OFS_CTRL     = 8'h00;
    localparam logic [7:0] MOL_OFS_MAX_MOT  = 8'h04;
    localparam logic [7:0] MOL_OFS_RATED    = 8'h08;
    localparam logic [7:0] MOL_OFS_PEAK_PM  = 8'h0C;
    localparam logic [7:0] MOL_OFS_PEAK_DUR = 8'h10;
    localparam logic [7:0] MOL_OFS_THRESH   = 8'h14;
    localparam logic [7:0] MOL_OFS_ACC_LO   = 8'h18;
    localparam logic [7:0] MOL_OFS_ACC_HI   = 8'h1C;
    localparam logic [7:0] MOL_OFS_LIMIT    = 8'h20;
    localparam logic [7:0] MOL_OFS_STATUS   = 8'h24;

    // Field positions
    localparam int MOL_CTRL_CLOSED_BIT = 0;
    localparam int MOL_STAT_ACTIVE_BIT = 0;

    // Reset values
    localparam logic        MOL_RST_CLOSED   = 1'b0;
    localparam logic [15:0] MOL_RST_MAX_MOT  = 16'h0000;
    localparam logic [15:0] MOL_RST_RATED    = 16'h0000;
    localparam logic [15:0] MOL_RST_PEAK_PM  = 16'h0000;
    localparam logic [15:0] MOL_RST_PEAK_DUR = 16'h0000;

    // Scaling
    localparam logic [15:0] MOL_PERMILLE_UNITY = 16'h03E8;
    localparam logic [15:0] MOL_MS_PER_S       = 16'h03E8;

    // Timing: one load update per control period
    localparam int MOL_CLK_MHZ        = 40;
    localparam int MOL_PERIOD_US      = 1000;
    localparam int MOL_PERIOD_CYCLES  = MOL_PERIOD_US * MOL_CLK_MHZ;

    // Bus encodings
    localparam logic [2:0] MOL_HSIZE_WORD = 3'h2;

    typedef enum logic {MOL_LIM_PEAK, MOL_LIM_RATED} mol_lim_e;

endpackage

// *** mol_limit_calc.sv ***
// Derives peak current, activation and load threshold from settings.
// Purely combinational; the caller registers the results.
`timescale 1ns/100ps
module mol_limit_calc
    import mol_pkg::*;
(
    // Settings
    input  wire logic        closed_loop,
    input  wire logic [15:0] max_motor_ma,
    input  wire logic [15:0] rated_ma,
    input  wire logic [15:0] peak_permille,
    input  wire logic [15:0] peak_dur_ms,
    // Results
    output logic             active,
    output logic      [15:0] peak_ma,
    output logic      [47:0] thr_sq,
    output logic      [31:0] thr_mas
);

    logic [31:0] peak_raw;
    logic [15:0] excess;
    logic [31:0] exc_dur;

    always_comb
    begin
        // Peak in mA from tenths of a percent of rated
        peak_raw = (rated_ma * peak_permille) / {16'h0000, MOL_PERMILLE_UNITY};
        // Clamp to absolute motor ceiling
        if (peak_raw > {16'h0000, max_motor_ma})
            peak_ma = max_motor_ma;
        else
            peak_ma = peak_raw[15:0];
        // Closed loop, peak above rated, duration given
        active = closed_loop && (peak_ma > rated_ma) && (peak_dur_ms != 16'h0000);
        excess = active ? (peak_ma - rated_ma) : 16'h0000;
        exc_dur = excess * peak_dur_ms;
        // Threshold in mAs, and in squared units for the compare
        thr_mas = exc_dur / {16'h0000, MOL_MS_PER_S};
        thr_sq = 48'(excess * excess) * {32'h0000_0000, peak_dur_ms};
    end

endmodule

// *** motor_overload_current_limiter_test.sv ***
// Self-checking bench for the motor overload current limiter.
// Assumes a zero-wait AHB-Lite slave and a shortened control period.
`timescale 1ns/100ps
module motor_overload_current_limiter_test;
    import mol_pkg::*;
    localparam int PER = 8;
    logic        hclk, hresetn, hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] motor_current_ma, current_cmd_ma, current_cmd_limited_ma;
    logic [15:0] applied_current_limit, r, pm, d, pk, mx;
    logic        protection_active, rd_dp, psamp;
    logic [31:0] rd_q[$];
    logic [32:0] pt_q[$];
    logic [15:0] pm_t[3] = '{16'd1000, 16'd800, 16'd1500};
    logic [15:0] du_t[3] = '{16'd5, 16'd5, 16'd0};
    int          fail_count, cmp_count, k, c;

    mol_overload_limiter #(.CTRL_PERIOD_CYCLES(PER)) i_mol_overload_limiter (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .motor_current_ma(motor_current_ma), .current_cmd_ma(current_cmd_ma),
        .current_cmd_limited_ma(current_cmd_limited_ma),
        .applied_current_limit(applied_current_limit),
        .protection_active(protection_active)
    );

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One single transfer, address phase then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [2:0] sz,
                       input logic [31:0] dat);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        hsize  <= sz;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dat;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        bus(a, 1'b1, MOL_HSIZE_WORD, dat);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(a, 1'b0, MOL_HSIZE_WORD, 32'h00000000);
    endtask

    task automatic pnote(input logic [32:0] exp);
        @(posedge hclk);
        pt_q.push_back(exp);
        psamp <= 1'b1;
        @(posedge hclk);
        psamp <= 1'b0;
    endtask

    task automatic cfg(input logic [15:0] m, input logic [15:0] rt, input logic [15:0] p,
                       input logic [15:0] du);
        wr(MOL_OFS_MAX_MOT, {16'h0000, m});
        wr(MOL_OFS_RATED, {16'h0000, rt});
        wr(MOL_OFS_PEAK_PM, {16'h0000, p});
        wr(MOL_OFS_PEAK_DUR, {16'h0000, du});
        wr(MOL_OFS_CTRL, 32'h00000001);
        repeat (2) @(posedge hclk);
    endtask

    // Output watcher takes the oldest note per result
    always @(posedge hclk)
    begin
        if (rd_dp)
        begin
            check({1'b0, hrdata}, {1'b0, rd_q.pop_front()});
            check({32'h00000000, hresp}, 33'h000000000);
        end
        if (psamp)
            check({protection_active, current_cmd_limited_ma, applied_current_limit},
                  pt_q.pop_front());
        rd_dp <= hsel & hready & htrans[1] & ~hwrite;
    end

    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    initial
    begin
        #(25 * 20000);
        fail_count++;
        give_verdict();
    end

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = MOL_HSIZE_WORD;
        hwdata = 32'h00000000;
        motor_current_ma = 16'h0000;
        current_cmd_ma = 16'h0000;
        psamp = 1'b0;
        rd_dp = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        k = $urandom(32'h3645b62f);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (k = 0; k <= 40; k += 4)
            rd(k[7:0], 32'h00000000);
        pnote({1'b0, 16'h0000, 16'h0000});
        wr(MOL_OFS_THRESH, 32'h00000077);
        rd(MOL_OFS_THRESH, 32'h00000000);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h00000000);
        wr(MOL_OFS_RATED, 32'hABCD1234);
        rd(MOL_OFS_RATED, 32'h00001234);
        bus(MOL_OFS_RATED, 1'b1, 3'h0, 32'h00000055);
        rd(MOL_OFS_RATED, 32'h00001234);
        wr(MOL_OFS_MAX_MOT, 32'h5A5A4321);
        rd(MOL_OFS_MAX_MOT, 32'h00004321);
        wr(MOL_OFS_PEAK_DUR, 32'h00010007);
        rd(MOL_OFS_PEAK_DUR, 32'h00000007);
        wr(MOL_OFS_CTRL, 32'hFFFFFFFF);
        rd(MOL_OFS_CTRL, 32'h00000001);
        for (c = 0; c < 2; c++)
        begin
            r = 16'd500 + 16'($urandom % 1000);
            pm = 16'd1200 + 16'($urandom % 1300);
            d = 16'd3 + 16'($urandom % 4);
            pk = 16'((32'(r) * 32'(pm)) / 1000);
            mx = (c == 0) ? 16'hFFFF : pk - 16'd50;
            pk = (c == 0) ? pk : mx;
            motor_current_ma <= pk;
            current_cmd_ma <= 16'hFFFF - 16'($urandom % 64);
            wr(MOL_OFS_CTRL, 32'h00000000);
            cfg(mx, r, pm, d);
            rd(MOL_OFS_STATUS, 32'h00000001);
            rd(MOL_OFS_THRESH, (32'(pk - r) * 32'(d)) / 1000);
            rd(MOL_OFS_LIMIT, {16'h0000, pk});
            pnote({1'b1, pk, pk});
            repeat (PER * d + PER) @(posedge hclk);
            rd(MOL_OFS_LIMIT, {16'h0000, r});
            pnote({1'b1, r, r});
            motor_current_ma <= 16'h0000;
            repeat (PER * 16) @(posedge hclk);
            rd(MOL_OFS_LIMIT, {16'h0000, pk});
            wr(MOL_OFS_CTRL, 32'h00000000);
            repeat (PER + 2) @(posedge hclk);
            rd(MOL_OFS_STATUS, 32'h00000000);
            rd(MOL_OFS_ACC_LO, 32'h00000000);
            rd(MOL_OFS_ACC_HI, 32'h00000000);
            motor_current_ma <= r + (pk - r) / 2;
            wr(MOL_OFS_CTRL, 32'h00000001);
            repeat (PER * d + PER) @(posedge hclk);
            rd(MOL_OFS_LIMIT, {16'h0000, pk});
        end
        for (k = 0; k < 3; k++)
        begin
            cfg(16'hFFFF, 16'd1000, pm_t[k], du_t[k]);
            rd(MOL_OFS_STATUS, 32'h00000000);
            pnote({1'b0, pm_t[k], pm_t[k]});
        end
        current_cmd_ma <= 16'd300;
        pnote({1'b0, 16'd300, 16'd1500});
        give_verdict();
    end
endmodule
